// >>> rtl/ballast_pkg.sv
// constants shared by the ballast sequencer and its helpers
// assumes a single 40 MHz system clock
package ballast_pkg;
  localparam int          SYS_CLK_HZ       = 40_000_000;
  localparam int          CLK_PERIOD_NS    = 25;
  // input glitch filter, 30 ns; least time, so round up
  localparam int          FILTER_NS        = 30;
  localparam int          FILTER_CYC       = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // timer pulse counts
  localparam logic [3:0]  PREHEAT_PULSES   = 4'h7;
  localparam logic [3:0]  IGNITE_PULSES    = 4'h1;
  // frequency ratio top/bottom fixed: period in ticks at top and bottom
  localparam int          SAW_WIDTH        = 12;
  localparam logic [11:0] SAW_TOP_PERIOD   = 12'h0C8;
  localparam logic [11:0] SAW_BOT_PERIOD   = 12'h1F4;
  // first low-side on-time is stretched by this many sawtooth cycles
  localparam logic [1:0]  BOOT_EXTRA_CYC   = 2'h2;
  // dead time floor in clocks, ceiling is a quarter of a bridge period
  localparam logic [11:0] DEAD_MIN_CYC     = 12'h004;
  // sample preheat sense during the last clocks of the low-side on-time
  localparam logic [11:0] PH_SAMPLE_WIN    = 12'h010;
  // vco control step per sawtooth cycle; two clocks keep the full sweep short
  localparam logic [11:0] VCO_STEP         = 12'h002;
  typedef enum logic [2:0] {ST_STARTUP, ST_PREHEAT, ST_IGNITE, ST_BURN, ST_POWERDOWN} seq_state_t;
  typedef enum logic [1:0] {PH_LOW, PH_GAP_LH, PH_HIGH, PH_GAP_HL} bridge_phase_t;
endpackage

// >>> rtl/glitch_filter.sv
// digital deglitcher for a comparator output
// assumes the input is synchronous to sys_clk
module glitch_filter
  import ballast_pkg::*;
#(
  parameter int LEN = FILTER_CYC
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // level in and filtered level out
  input  wire logic raw_in,
  output logic      clean_out
);
  logic [7:0] cnt_r;

  // a new level must hold for LEN clocks before it is passed on
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r     <= 8'h00;
      clean_out <= 1'b0;
    end else if (raw_in == clean_out) begin
      cnt_r <= 8'h00;
    end else if (cnt_r >= 8'(LEN - 1)) begin
      cnt_r     <= 8'h00;
      clean_out <= raw_in;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule

// >>> rtl/pulse_timer.sv
// pulse-counting timer standing in for the timing capacitor
// assumes cap_pulse marks one charge/discharge pulse of the timer cap
module pulse_timer
  import ballast_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // control
  input  wire logic       start,
  input  wire logic       hold_clear,
  input  wire logic [3:0] target,
  input  wire logic       cap_pulse,
  // status
  output logic            running,
  output logic            done,
  output logic            discharge
);
  logic [3:0] count_r;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_r <= 4'h0;
      running <= 1'b0;
      done    <= 1'b0;
    end else if (hold_clear) begin
      count_r <= 4'h0;
      running <= 1'b0;
      done    <= 1'b0;
    end else if (start) begin
      count_r <= 4'h0;
      running <= 1'b1;
      done    <= 1'b0;
    end else if (running && cap_pulse) begin
      if (count_r + 4'h1 >= target) begin
        running <= 1'b0;
        done    <= 1'b1;
      end
      count_r <= count_r + 4'h1;
    end else begin
      done <= 1'b0;
    end
  end

  // idle: cap is pulled to zero with the fixed sink
  assign discharge = !running;
endmodule

// >>> rtl/lamp_ballast_sequencer.sv
// operating-state sequencer, oscillator and gate timing of the ballast
// assumes comparator outputs arrive as levels synchronous to sys_clk
// Notes on behaviour
// - in start-up: logic reset, both switches off, both cap pins held at zero
// - supply reaching its on threshold ends start-up and starts oscillation
// - high-side gate forced low while floating supply is under lockout
// - sawtooth runs at twice the bridge frequency
// - high and low switches conduct alternately, about half the period each
// - start at top frequency, low side first, first on-time stretched
// - top to bottom frequency ratio is a fixed constant
// - dead time has fixed floor, capped at a quarter bridge period
// - dead time ends on detected half-bridge slope
// - slope sense filtered against short disturbances
// - timer counts cap pulses: preheat seven, ignition at most one
// - timer starts after start-up and again when lamp passes warn level
// - idle timer discharges its cap toward zero
// - preheat: frequency falls, preheat sense sampled only at low-side on end
// - preheat detect raises frequency; cleared each high-side on-time
// - preheat timed from oscillation start, average loop off throughout
// - preheat sense filtered against short disturbances
// - preheat expiry enters ignition, control ramps frequency steadily down
// - reaching bottom frequency enters burn and enables average loop
// - in burn, average loop regulates once sense reaches reference
// - lamp over limit in ignition holds the voltage at the limit
// - lamp still over warn at ignition end latches power-down
// - power-down stops oscillator, both switches off
module lamp_ballast_sequencer
  import ballast_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // supply comparators
  input  wire logic supply_on,
  input  wire logic floating_supply_ok,
  // sense comparators
  input  wire logic slope_sense_input,
  input  wire logic preheat_sense_input,
  input  wire logic lamp_over_warn,
  input  wire logic lamp_over_limit,
  input  wire logic avg_reached,
  input  wire logic timer_cap_pulse,
  // gate drive
  output logic      high_side_switch,
  output logic      low_side_switch,
  // analogue pin controls
  output logic      osc_cap_clamp,
  output logic      timer_cap_clamp,
  output logic      timer_cap_discharge,
  output logic      vco_discharge,
  output logic      vco_charge,
  output logic      lamp_limit_regulate,
  output logic      average_current_loop,
  output logic      avg_loop_in_control,
  // status
  output logic [2:0] seq_state
);
  seq_state_t    state_r;
  seq_state_t    state_nxt;
  bridge_phase_t phase_r;
  logic [11:0]   saw_r;
  logic [11:0]   period_r;
  logic [11:0]   gap_r;
  logic          saw_wrap;
  logic [1:0]    boot_r;
  logic          first_r;
  logic          slope_clean;
  logic          ph_clean;
  logic          ph_detect_r;
  logic          warn_seen_r;
  logic          tmr_start;
  logic [3:0]    tmr_target;
  logic          tmr_running;
  logic          tmr_done;
  logic          tmr_discharge;
  logic          osc_run;
  logic          in_startup;

  ////////////////////////////////////////////////////////////////////////////
  // one vco step toward bottom or top frequency, clamped at the limit
  function automatic logic [11:0] step_slower(input logic [11:0] p);
    logic [11:0] q;
    q = p;
    if (p < SAW_BOT_PERIOD) begin
      q = p + VCO_STEP;
    end
    return q;
  endfunction

  function automatic logic [11:0] step_faster(input logic [11:0] p);
    logic [11:0] q;
    q = p;
    if (p > SAW_TOP_PERIOD) begin
      q = p - VCO_STEP;
    end
    return q;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // input filters
  glitch_filter #(.LEN(FILTER_CYC)) u_slope_filt (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .raw_in    (slope_sense_input),
    .clean_out (slope_clean)
  );

  glitch_filter #(.LEN(FILTER_CYC)) u_ph_filt (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .raw_in    (preheat_sense_input),
    .clean_out (ph_clean)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  assign in_startup = (state_r == ST_STARTUP);
  assign osc_run    = (state_r == ST_PREHEAT) || (state_r == ST_IGNITE) || (state_r == ST_BURN);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_STARTUP: begin
        if (supply_on) begin
          state_nxt = ST_PREHEAT;
        end
      end
      ST_PREHEAT: begin
        if (tmr_done) begin
          state_nxt = ST_IGNITE;
        end
      end
      ST_IGNITE: begin
        if (tmr_done && lamp_over_warn) begin
          state_nxt = ST_POWERDOWN;
        end else if (period_r >= SAW_BOT_PERIOD) begin
          state_nxt = ST_BURN;
        end
      end
      ST_BURN: begin
        // over-limit in burn means the lamp went out: try to re-ignite
        if (lamp_over_limit) begin
          state_nxt = ST_IGNITE;
        end else if (tmr_done && lamp_over_warn) begin
          state_nxt = ST_POWERDOWN;
        end
      end
      ST_POWERDOWN: begin
        // latched until the supply collapses
        state_nxt = ST_POWERDOWN;
      end
      default: begin
        state_nxt = ST_STARTUP;
      end
    endcase
  end

  // power-down leaves only through rst_b, i.e. supply collapse
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_STARTUP;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign seq_state = state_r;

  ////////////////////////////////////////////////////////////////////////////
  // timer: preheat count from oscillation start, ignition on warn crossing
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      warn_seen_r <= 1'b0;
    end else if (!osc_run) begin
      warn_seen_r <= 1'b0;
    end else begin
      warn_seen_r <= lamp_over_warn;
    end
  end

  // each fresh warn crossing in ignition or burn reopens the one-pulse ignition window
  always_comb begin
    tmr_start  = 1'b0;
    tmr_target = IGNITE_PULSES;
    if (in_startup && supply_on) begin
      tmr_start  = 1'b1;
      tmr_target = PREHEAT_PULSES;
    end else if (state_r == ST_PREHEAT) begin
      tmr_target = PREHEAT_PULSES;
    end else if ((state_r == ST_IGNITE || state_r == ST_BURN) && lamp_over_warn && !warn_seen_r) begin
      tmr_start = 1'b1;
    end
  end

  pulse_timer u_timer (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .start      (tmr_start),
    .hold_clear (in_startup && !supply_on),
    .target     (tmr_target),
    .cap_pulse  (timer_cap_pulse),
    .running    (tmr_running),
    .done       (tmr_done),
    .discharge  (tmr_discharge)
  );

  assign timer_cap_discharge = tmr_discharge && !in_startup;
  assign timer_cap_clamp     = in_startup;
  assign osc_cap_clamp       = !osc_run;

  ////////////////////////////////////////////////////////////////////////////
  // vco: period in clocks stands for the control cap voltage
  // ratio of the two limits is a constant, never software visible
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      period_r <= SAW_TOP_PERIOD;
    end else if (!osc_run) begin
      period_r <= SAW_TOP_PERIOD;
    end else if (saw_wrap) begin
      case (state_r)
        ST_PREHEAT: begin
          if (ph_detect_r) begin
            period_r <= step_faster(period_r);
          end else begin
            period_r <= step_slower(period_r);
          end
        end
        ST_IGNITE: begin
          // held while the lamp sits at its voltage limit
          if (!lamp_over_limit) begin
            period_r <= step_slower(period_r);
          end
        end
        ST_BURN: begin
          if (avg_reached) begin
            period_r <= step_faster(period_r);
          end else begin
            period_r <= step_slower(period_r);
          end
        end
        default: begin
          period_r <= period_r;
        end
      endcase
    end
  end

  assign vco_discharge       = (state_r == ST_PREHEAT) && ph_detect_r;
  assign vco_charge          = (state_r == ST_IGNITE) && !lamp_over_limit;
  assign lamp_limit_regulate = (state_r == ST_IGNITE) && lamp_over_limit;
  assign average_current_loop = (state_r == ST_BURN);
  assign avg_loop_in_control = (state_r == ST_BURN) && avg_reached;

  ////////////////////////////////////////////////////////////////////////////
  // sawtooth: two sawtooth cycles make one bridge period
  assign saw_wrap = osc_run && (saw_r >= period_r - 12'h001);

  // a stopped bridge keeps the sawtooth at zero, so a restart is clean
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      saw_r <= 12'h000;
    end else if (!osc_run || saw_wrap) begin
      saw_r <= 12'h000;
    end else begin
      saw_r <= saw_r + 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bridge phases: each half but the first low opens with a dead gap then conducts
  // gap is capped at half a sawtooth cycle, i.e. a quarter bridge period
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= PH_LOW;
      gap_r   <= 12'h000;
      boot_r  <= 2'h0;
      first_r <= 1'b1;
    end else if (!osc_run) begin
      phase_r <= PH_LOW;
      gap_r   <= 12'h000;
      boot_r  <= 2'h0;
      first_r <= 1'b1;
    end else begin
      case (phase_r)
        PH_LOW: begin
          // the first low phase also charges the bootstrap cap
          if (saw_wrap) begin
            if (first_r && boot_r < BOOT_EXTRA_CYC) begin
              boot_r <= boot_r + 2'h1;
            end else begin
              first_r <= 1'b0;
              phase_r <= PH_GAP_LH;
              gap_r   <= 12'h000;
            end
          end
        end
        PH_GAP_LH, PH_GAP_HL: begin
          // the floor guards against ringing that the filter let through
          gap_r <= gap_r + 12'h001;
          if ((gap_r >= DEAD_MIN_CYC && slope_clean) || (gap_r >= (period_r >> 1))) begin
            phase_r <= (phase_r == PH_GAP_LH) ? PH_HIGH : PH_LOW;
          end
        end
        PH_HIGH: begin
          if (saw_wrap) begin
            phase_r <= PH_GAP_HL;
            gap_r   <= 12'h000;
          end
        end
        default: begin
          phase_r <= PH_LOW;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // preheat detection: looked at only near end of low-side conduction
  // flag survives the dead gap, so the vco keeps discharging until high side
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ph_detect_r <= 1'b0;
    end else if (state_r != ST_PREHEAT || phase_r == PH_HIGH) begin
      ph_detect_r <= 1'b0;
    end else if (phase_r == PH_LOW && ph_clean && (saw_r + PH_SAMPLE_WIN >= period_r)) begin
      ph_detect_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // gate outputs registered; start-up and power-down force both off
  // registered so no decode glitch reaches a gate driver; a one-clock floating_supply_ok drop still reaches the high side
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      high_side_switch <= 1'b0;
      low_side_switch  <= 1'b0;
    end else if (!osc_run || state_nxt == ST_POWERDOWN) begin
      high_side_switch <= 1'b0;
      low_side_switch  <= 1'b0;
    end else begin
      high_side_switch <= (phase_r == PH_HIGH) && floating_supply_ok;
      low_side_switch  <= (phase_r == PH_LOW);
    end
  end
endmodule

// >>> test/ballast_asserts.sv
// port-level assertions for the ballast sequencer
// assumes one sys_clk domain with active-low rst_b
module ballast_checker (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_b,
  // sense and supply
  input wire logic       supply_on,
  input wire logic       floating_supply_ok,
  input wire logic       lamp_over_limit,
  input wire logic       avg_reached,
  // outputs watched
  input wire logic       high_side_switch,
  input wire logic       low_side_switch,
  input wire logic       osc_cap_clamp,
  input wire logic       timer_cap_clamp,
  input wire logic       vco_discharge,
  input wire logic       vco_charge,
  input wire logic       lamp_limit_regulate,
  input wire logic       average_current_loop,
  input wire logic       avg_loop_in_control,
  input wire logic [2:0] seq_state
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////
  a_startup_quiet: assert property (seq_state == 3'h0 |-> !high_side_switch && !low_side_switch
    && osc_cap_clamp && timer_cap_clamp) else $error("start-up outputs not quiet");
  a_supply_start: assert property (seq_state == 3'h0 && supply_on |=> seq_state == 3'h1)
    else $error("supply on did not start preheat");
  a_hs_lockout: assert property (!floating_supply_ok && !$past(floating_supply_ok) |-> !high_side_switch)
    else $error("high side driven under lockout");
  a_low_first: assert property ($past(seq_state) == 3'h0 && seq_state == 3'h1 |-> ##1 low_side_switch)
    else $error("first conduction not low side");
  a_no_overlap: assert property (!(high_side_switch && low_side_switch))
    else $error("both switches on");
  a_dead_floor: assert property ($fell(low_side_switch) |-> !high_side_switch [*4])
    else $error("dead time below floor");
  a_dead_cap: assert property ($fell(low_side_switch) && floating_supply_ok |-> ##[1:260]
    (high_side_switch || !floating_supply_ok || seq_state == 3'h4)) else $error("dead time not ended");
  a_detect_preheat: assert property (vco_discharge |-> seq_state == 3'h1)
    else $error("preheat detect outside preheat");
  a_detect_clear: assert property ($rose(high_side_switch) && $past(vco_discharge) |-> !vco_discharge)
    else $error("preheat detect not cleared");
  a_avg_off: assert property (seq_state == 3'h1 |-> !average_current_loop && !avg_loop_in_control)
    else $error("average loop on in preheat");
  a_ignite_ramp: assert property (seq_state == 3'h2 |-> vco_charge == !lamp_over_limit
    && lamp_limit_regulate == lamp_over_limit) else $error("ignition control wrong");
  a_burn_loop: assert property (seq_state == 3'h3 |-> average_current_loop
    && avg_loop_in_control == avg_reached) else $error("burn loop wrong");
  a_pd_latch: assert property (seq_state == 3'h4 |=> seq_state == 3'h4 && osc_cap_clamp
    && !high_side_switch && !low_side_switch) else $error("power-down not held");
  a_state_step: assert property (seq_state != $past(seq_state) |-> {$past(seq_state), seq_state}
    inside {6'h01, 6'h0A, 6'h13, 6'h1A, 6'h14, 6'h1C}) else $error("illegal state step");
  c_burn: cover property (seq_state == 3'h3);
  c_down: cover property (seq_state == 3'h4);
  c_detect: cover property (vco_discharge);
  c_limit: cover property (lamp_limit_regulate);
endmodule

bind lamp_ballast_sequencer ballast_checker u_ballast_checker (.sys_clk, .rst_b, .supply_on,
  .floating_supply_ok, .lamp_over_limit, .avg_reached, .high_side_switch, .low_side_switch,
  .osc_cap_clamp, .timer_cap_clamp, .vco_discharge, .vco_charge, .lamp_limit_regulate,
  .average_current_loop, .avg_loop_in_control, .seq_state);

// >>> test/bridge_load_model.sv
// half-bridge midpoint and timer capacitor as the sequencer sees them
// assumes registered gates; outputs change just after sys_clk rises
module bridge_load_model #(
  parameter int PULSE_GAP = 3000
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // from the sequencer
  input  wire logic high_side_switch,
  input  wire logic low_side_switch,
  input  wire logic timer_cap_clamp,
  input  wire logic timer_cap_discharge,
  input  wire logic slow,
  // to the sequencer
  output logic      slope_sense_input,
  output logic      timer_cap_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  int gap_cnt;
  int cap_cnt;
  ////////////////////////////////////////////////////////////////
  // a one-cycle ringing spike precedes the real swing; slow never swings
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b || high_side_switch || low_side_switch) begin
      gap_cnt           <= 0;
      slope_sense_input <= 1'b0;
    end else begin
      gap_cnt           <= gap_cnt + 1;
      slope_sense_input <= !slow && (gap_cnt == 4 || gap_cnt >= 8);
    end
  end
  // cap ramps only while the timer runs
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b || timer_cap_clamp || timer_cap_discharge) begin
      cap_cnt         <= 0;
      timer_cap_pulse <= 1'b0;
    end else begin
      cap_cnt         <= (cap_cnt == PULSE_GAP - 1) ? 0 : cap_cnt + 1;
      timer_cap_pulse <= (cap_cnt == PULSE_GAP - 1);
    end
  end
endmodule

// >>> test/lamp_ballast_sequencer_bench.sv
// self-checking bench for the ballast sequencer
// assumes the bridge model and the bound checker; run is about 58k clocks
module lamp_ballast_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, rst_b = 1'b0, supply_on = 1'b0, floating_supply_ok = 1'b1, slow = 1'b0;
  logic preheat_sense_input = 1'b0, lamp_over_warn = 1'b0, lamp_over_limit = 1'b0, avg_reached = 1'b0;
  logic slope_sense_input, timer_cap_pulse, high_side_switch, low_side_switch, osc_cap_clamp;
  logic timer_cap_clamp, timer_cap_discharge, vco_discharge, vco_charge, lamp_limit_regulate;
  logic average_current_loop, avg_loop_in_control;
  logic [2:0] seq_state;
  int fails = 0, total_checks = 0, pulses = 0, g;
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (timer_cap_pulse === 1'b1) pulses <= pulses + 1;
  lamp_ballast_sequencer u_lamp_ballast_sequencer (.sys_clk, .rst_b, .supply_on, .floating_supply_ok,
    .slope_sense_input, .preheat_sense_input, .lamp_over_warn, .lamp_over_limit, .avg_reached,
    .timer_cap_pulse, .high_side_switch, .low_side_switch, .osc_cap_clamp, .timer_cap_clamp,
    .timer_cap_discharge, .vco_discharge, .vco_charge, .lamp_limit_regulate, .average_current_loop,
    .avg_loop_in_control, .seq_state);
  bridge_load_model u_bridge_load_model (.sys_clk, .rst_b, .high_side_switch, .low_side_switch,
    .timer_cap_clamp, .timer_cap_discharge, .slow, .slope_sense_input, .timer_cap_pulse);
  ////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // bounded wait on a level; a timeout ends the run
  task automatic wait_for(input logic [2:0] s, input int lim);
    int n;
    n = 0;
    while (seq_state !== s && n < lim) begin
      tick(1);
      n++;
    end
    if (n >= lim) begin
      fails++;
      close_out();
    end
  endtask
  // length of the dead time after the next conduction
  task automatic gap_len(output int len);
    int n;
    n = 0;
    len = 0;
    while ((high_side_switch | low_side_switch) !== 1'b1 && n < 3000) begin tick(1); n++; end
    while ((high_side_switch | low_side_switch) === 1'b1 && n < 3000) begin tick(1); n++; end
    while ((high_side_switch | low_side_switch) === 1'b0 && n < 3000) begin tick(1); n++; len++; end
    if (n >= 3000) begin
      fails++;
      close_out();
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_startup();
    int n;
    n = 0;
    tick(20);
    check(8'({high_side_switch, low_side_switch, osc_cap_clamp, timer_cap_clamp}), 8'h03);
    @(posedge sys_clk) supply_on <= 1'b1;
    wait_for(3'h1, 4);
    check(8'(osc_cap_clamp), 8'h00);
    tick(1);
    check(8'({high_side_switch, low_side_switch}), 8'h01);
    while (low_side_switch === 1'b1 && n < 1000) begin tick(1); n++; end
    check(8'(n >= 500 && n <= 620), 8'h01);
    $display("startup done");
  endtask
  task automatic t_gaps();
    gap_len(g);
    check(8'(g >= 9 && g <= 20), 8'h01);
    @(posedge sys_clk) slow <= 1'b1;
    gap_len(g);
    gap_len(g);
    check(8'(g >= 90 && g <= 140), 8'h01);
    @(posedge sys_clk) slow <= 1'b0;
    @(posedge sys_clk) floating_supply_ok <= 1'b0;
    tick(2);
    repeat (600) begin tick(1); check(8'(high_side_switch), 8'h00); end
    @(posedge sys_clk) floating_supply_ok <= 1'b1;
    $display("gaps done");
  endtask
  task automatic t_preheat();
    int n;
    n = 0;
    // one-clock spikes for longer than a bridge period must never count
    repeat (200) begin
      @(posedge sys_clk) preheat_sense_input <= 1'b1;
      @(posedge sys_clk) preheat_sense_input <= 1'b0;
      tick(1);
      check(8'(vco_discharge), 8'h00);
    end
    @(posedge sys_clk) preheat_sense_input <= 1'b1;
    while (vco_discharge !== 1'b1 && n < 1500) begin tick(1); n++; end
    check(8'({vco_discharge, low_side_switch}), 8'h03);
    tick(1500);
    @(posedge sys_clk) preheat_sense_input <= 1'b0;
    wait_for(3'h2, 30000);
    check(8'(pulses), 8'h07);
    $display("preheat done");
  endtask
  task automatic t_ignite_burn();
    check(8'({vco_charge, lamp_limit_regulate}), 8'h02);
    @(posedge sys_clk) lamp_over_limit <= 1'b1;
    tick(2);
    check(8'({vco_charge, lamp_limit_regulate}), 8'h01);
    @(posedge sys_clk) lamp_over_limit <= 1'b0;
    wait_for(3'h3, 110000);
    check(8'({average_current_loop, avg_loop_in_control, timer_cap_discharge}), 8'h05);
    @(posedge sys_clk) avg_reached <= 1'b1;
    tick(2);
    check(8'(avg_loop_in_control), 8'h01);
    $display("ignite and burn done");
  endtask
  task automatic t_failure();
    @(posedge sys_clk) lamp_over_warn <= 1'b1;
    tick(2);
    check(8'(timer_cap_discharge), 8'h00);
    @(posedge sys_clk) lamp_over_limit <= 1'b1;
    tick(4);
    @(posedge sys_clk) lamp_over_limit <= 1'b0;
    wait_for(3'h4, 8000);
    @(posedge sys_clk) lamp_over_warn <= 1'b0;
    tick(200);
    check(8'({seq_state, high_side_switch, low_side_switch, osc_cap_clamp}), 8'h21);
    @(posedge sys_clk) rst_b <= 1'b0;
    tick(16);
    check(8'(seq_state), 8'h00);
    $display("failure done");
  endtask
  initial begin
    tick(16);
    @(posedge sys_clk) rst_b <= 1'b1;
    t_startup();
    t_gaps();
    t_preheat();
    t_ignite_burn();
    t_failure();
    close_out();
  end
endmodule
